// File: dv/external_pin_interrupt_unit_tb_top.sv
// self-checking bench of the external pin interrupt unit
module external_pin_interrupt_unit_tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    typedef struct {logic [2:0] a; logic [7:0] w; logic [7:0] e;} row_t;

    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        clk_en = 1'b1;
    logic        gie = 1'b0;
    logic        ack_en = 1'b0;
    logic        slow = 1'b0;
    logic        sleep = 1'b0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [2:0]  addr = 3'h0;
    logic [7:0]  wdata = 8'h00;
    logic [20:0] pins = 21'h1f_ffff;
    wire logic [7:0] rdata;
    wire logic [7:0] line_req;
    wire logic [7:0] line_ack;
    wire logic [1:0] group_ack;
    wire logic       g0;
    wire logic       g1;
    wire logic [9:0] reqs = {g1, g0, line_req};
    int          fail_count = 0;
    int          checked = 0;
    // register writes and what each reads back
    row_t rows [6] = '{'{3'h0, 8'h1b, 8'h1b}, '{3'h1, 8'he4, 8'he4},
        '{3'h2, 8'ha5, 8'ha5}, '{3'h4, 8'hff, 8'h03},
        '{3'h6, 8'h3c, 8'h3c}, '{3'h7, 8'hff, 8'h1f}};

    ////////////////////////////////////////////////////////////////////////
    // 10 MHz clock
    always #50 clk = ~clk;

    external_pin_interrupt_unit u_dut (.clk(clk), .rst_n(rst_n),
        .clk_en(clk_en), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr),
        .reg_rd(rd), .reg_rdata(rdata), .ext_irq_pins(pins[7:0]),
        .pin_change_inputs(pins[20:8]), .global_irq_enable(gie),
        .sleep_active(sleep), .line_ack(line_ack), .group_ack(group_ack),
        .line_req(line_req), .pin_change_req_group0(g0),
        .pin_change_req_group1(g1));

    irq_processor_model u_cpu (.clk(clk), .rst_n(rst_n), .ack_en(ack_en),
        .slow(slow), .line_req(line_req), .group_req({g1, g0}),
        .line_ack(line_ack), .group_ack(group_ack));

    ////////////////////////////////////////////////////////////////////////
    // compare, bus and pin tasks
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] %0t read %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] %0t request %b expected %b", $time, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [2:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk_byte(rdata, e);
    endtask

    task automatic pin(input int b, input logic v);
        @(posedge clk);
        pins[b] <= v;
    endtask

    // bounded wait on one request bit, then compare
    task automatic wait_req(input int i, input logic v);
        int n;
        n = 0;
        while (reqs[i] !== v && n < 8)
        begin
            @(posedge clk);
            #1 n++;
        end
        chk_bit(reqs[i], v);
    endtask

    task automatic wrap_up();
        if (fail_count == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // watchdog: the tests need well under a thousand cycles
    initial
    begin
        #500000;
        fail_count++;
        wrap_up();
    end

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 8; i++)
            rd_reg(3'(i), 8'h00);
        foreach (rows[i])
        begin
            wr_reg(rows[i].a, rows[i].w);
            rd_reg(rows[i].a, rows[i].e);
        end
        for (int i = 0; i < 8; i++)
            wr_reg(3'(i), 8'h00);
        // every edge code on a clockless line and on a sampled line
        for (int k = 0; k < 2; k++)
        begin
            int li;
            li = k * 4;
            for (int c = 1; c < 4; c++)
            begin
                wr_reg(3'(li / 4), 8'(c << (2 * (li % 4))));
                wr_reg(3'h3, 8'hff);
                pin(li, 1'b0);
                repeat (5) @(posedge clk);
                rd_reg(3'h3, c != 3 ? 8'h01 << li : 8'h00);
                wr_reg(3'h3, 8'hff);
                pin(li, 1'b1);
                repeat (5) @(posedge clk);
                rd_reg(3'h3, c != 2 ? 8'h01 << li : 8'h00);
            end
        end
        // sub-cycle rising pulse on line 3, held off by the global enable
        wr_reg(3'h0, 8'hc0);
        wr_reg(3'h3, 8'hff);
        wr_reg(3'h2, 8'h08);
        pin(3, 1'b0);
        @(posedge clk);
        #20 pins[3] = 1'b1;
        #60 pins[3] = 1'b0;
        repeat (5) @(posedge clk);
        #1 chk_bit(reqs[3], 1'b0);
        rd_reg(3'h3, 8'h08);
        gie <= 1'b1;
        wait_req(3, 1'b1);
        ack_en <= 1'b1;
        wait_req(3, 1'b0);
        ack_en <= 1'b0;
        wr_reg(3'h2, 8'h20);
        // low level on line 5, held by the source as long as needed
        wr_reg(3'h3, 8'hff);
        pin(5, 1'b0);
        wait_req(5, 1'b1);
        repeat (6) @(posedge clk);
        #1 chk_bit(reqs[5], 1'b1);
        rd_reg(3'h3, 8'h00);
        gie <= 1'b0;
        wait_req(5, 1'b0);
        gie <= 1'b1;
        wait_req(5, 1'b1);
        pin(5, 1'b1);
        wait_req(5, 1'b0);
        // pin-change groups: masked pins only, one group at a time
        wr_reg(3'h6, 8'h04);
        wr_reg(3'h7, 8'h10);
        wr_reg(3'h4, 8'h03);
        pin(11, 1'b0);
        repeat (5) @(posedge clk);
        #1 chk_bit(reqs[8], 1'b0);
        pin(10, 1'b0);
        wait_req(8, 1'b1);
        rd_reg(3'h5, 8'h01);
        wr_reg(3'h5, 8'h01);
        wait_req(8, 1'b0);
        // a toggle while the clock is held is still caught
        clk_en <= 1'b0;
        pin(10, 1'b1);
        repeat (3) @(posedge clk);
        clk_en <= 1'b1;
        wait_req(8, 1'b1);
        wr_reg(3'h5, 8'h01);
        pin(20, 1'b0);
        wait_req(9, 1'b1);
        gie <= 1'b0;
        wait_req(9, 1'b0);
        gie <= 1'b1;
        wait_req(9, 1'b1);
        slow <= 1'b1;
        ack_en <= 1'b1;
        repeat (2) @(posedge clk);
        #1 chk_bit(reqs[9], 1'b1);
        wait_req(9, 1'b0);
        ack_en <= 1'b0;
        rd_reg(3'h5, 8'h00);
        // masked lines 3-0 lose their buffers in sleep; the forced low
        // is a falling edge on line 0 while lines 1-3 sit in level mode
        wr_reg(3'h0, 8'h02);
        wr_reg(3'h3, 8'hff);
        sleep <= 1'b1;
        repeat (5) @(posedge clk);
        rd_reg(3'h3, 8'h01);
        @(posedge clk);
        sleep <= 1'b0;
        repeat (5) @(posedge clk);
        rd_reg(3'h3, 8'h01);
        // a reset in mid-run clears registers and pending flags
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd_reg(3'h3, 8'h00);
        rd_reg(3'h1, 8'h00);
        wrap_up();
    end
endmodule

// File: dv/irq_processor_model.sv
// processor side model: enters the handler of pending requests
module irq_processor_model
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // behaviour knobs
    input  wire logic       ack_en,
    input  wire logic       slow,
    // requests in, handler entry out
    input  wire logic [7:0] line_req,
    input  wire logic [1:0] group_req,
    output logic      [7:0] line_ack,
    output logic      [1:0] group_ack
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [1:0] wait_cnt;

    ////////////////////////////////////////////////////////////////////////
    // one-cycle entry pulse; slow mode waits three cycles like a busy core
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wait_cnt  <= 2'h0;
            line_ack  <= 8'h00;
            group_ack <= 2'h0;
        end
        else
        begin
            line_ack  <= 8'h00;
            group_ack <= 2'h0;
            // no second entry while the last one is still landing
            if (!ack_en || {line_req, group_req} == 10'h000
                || {line_ack, group_ack} != 10'h000)
                wait_cnt <= 2'h0;
            else if (slow && wait_cnt != 2'h3)
                wait_cnt <= wait_cnt + 2'h1;
            else
            begin
                line_ack  <= line_req;
                group_ack <= group_req;
                wait_cnt  <= 2'h0;
            end
        end
    end
endmodule

// File: src/edge_toggle_catcher.sv
// clockless edge catcher: one toggle per rising and per falling pin edge
module edge_toggle_catcher
(
    // pin side
    input  wire logic pin,
    // reset
    input  wire logic rst_n,
    // toggle outputs, read through synchronisers in the clock domain
    output logic      rise_toggle,
    output logic      fall_toggle
);

    // the pin itself clocks these, so a pulse far shorter than a clock
    // period, or one arriving with the clock stopped, is still recorded
    always_ff @(posedge pin or negedge rst_n)
    begin
        if (!rst_n)
            rise_toggle <= 1'b0;
        else
            rise_toggle <= ~rise_toggle;
    end

    // falling edges on their own flip-flop so both edges survive
    always_ff @(negedge pin or negedge rst_n)
    begin
        if (!rst_n)
            fall_toggle <= 1'b0;
        else
            fall_toggle <= ~fall_toggle;
    end

endmodule

// File: src/ext_irq_pkg.sv
// constants, register map and field layout of the external interrupt unit
package ext_irq_pkg;

    // register bus shape
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;

    // register indices on the plain register port
    localparam logic [2:0] OFS_SENSE_LO  = 3'h0;
    localparam logic [2:0] OFS_SENSE_HI  = 3'h1;
    localparam logic [2:0] OFS_LINE_MASK = 3'h2;
    localparam logic [2:0] OFS_LINE_FLAG = 3'h3;
    localparam logic [2:0] OFS_GRP_EN    = 3'h4;
    localparam logic [2:0] OFS_GRP_FLAG  = 3'h5;
    localparam logic [2:0] OFS_PC_MASK0  = 3'h6;
    localparam logic [2:0] OFS_PC_MASK1  = 3'h7;

    // reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [1:0] RST_GRP  = 2'h0;
    localparam logic [4:0] RST_PCM1 = 5'h00;

    // line and pin counts
    localparam int N_LINES   = 8;
    localparam int N_ASYNC   = 4;   // lines caught without the clock
    localparam int N_PC      = 13;
    localparam int N_PC0     = 8;   // pins in group 0
    localparam int N_PC1     = 5;   // pins in group 1
    localparam int N_CATCH   = N_ASYNC + N_PC;
    localparam int SENSE_W   = 2;

    // group bit positions
    localparam int GRP0_BIT = 0;
    localparam int GRP1_BIT = 1;

    // sense field codes
    localparam logic [1:0] SENSE_LOW  = 2'h0;
    localparam logic [1:0] SENSE_ANY  = 2'h1;
    localparam logic [1:0] SENSE_FALL = 2'h2;
    localparam logic [1:0] SENSE_RISE = 2'h3;

endpackage

// File: src/external_pin_interrupt_unit.sv
// external line and pin-change interrupt detection with its registers
module external_pin_interrupt_unit
(
    // clock, reset, enable
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       clk_en,
    // register port
    input  wire logic [2:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // pins
    input  wire logic [7:0]  ext_irq_pins,
    input  wire logic [12:0] pin_change_inputs,
    // processor side
    input  wire logic       global_irq_enable,
    input  wire logic       sleep_active,
    input  wire logic [7:0] line_ack,
    input  wire logic [1:0] group_ack,
    output logic      [7:0] line_req,
    output logic            pin_change_req_group0,
    output logic            pin_change_req_group1
);

    ////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic [7:0]  sense_lo;
        logic [7:0]  sense_hi;
        logic [7:0]  mask;
        logic [7:0]  flags;
        logic [1:0]  grp_en;
        logic [1:0]  grp_flags;
        logic [7:0]  pc_mask0;
        logic [4:0]  pc_mask1;
        logic [7:0]  pin_s1;     // first synchroniser stage, all lines
        logic [7:0]  pin_s2;
        logic [3:0]  prev_hi;    // previous sample of lines 7-4
        logic [16:0] rise_s1;
        logic [16:0] rise_s2;
        logic [16:0] rise_s3;
        logic [16:0] fall_s1;
        logic [16:0] fall_s2;
        logic [16:0] fall_s3;
        logic [7:0]  rdata;
        logic [7:0]  line_req;
        logic        grp_req0;
        logic        grp_req1;
    } unit_state_t;

    unit_state_t st_reg;
    unit_state_t st_next;

    logic [16:0] catch_pin;
    logic [16:0] rise_tog;
    logic [16:0] fall_tog;
    logic [16:0] rise_ev;
    logic [16:0] fall_ev;
    logic [7:0]  ext_rise;
    logic [7:0]  ext_fall;
    logic [15:0] sense_all;
    logic [7:0]  line_lvl;
    logic [7:0]  line_set;
    logic [7:0]  line_low;
    logic [12:0] pc_change;
    logic [3:0]  buf_en;
    logic        grp_set0;
    logic        grp_set1;
    logic        wr_flag;
    logic        wr_gflag;
    logic [7:0]  flags_nx;
    logic [1:0]  gflags_nx;

    ////////////////////////////////////////////////////////////////////////
    // clockless capture

    // input buffers of lines 3-0 switch off in sleep while masked; the
    // forced low may itself look like an edge and set a flag
    assign buf_en = ~({4{sleep_active}} & ~st_reg.mask[3:0]);

    // pins are read straight from the pad whatever their direction
    assign catch_pin = {pin_change_inputs,
                        ext_irq_pins[3:0] & buf_en};

    // one catcher per clockless input; no clock reaches them
    genvar gc;
    generate
        for (gc = 0; gc < ext_irq_pkg::N_CATCH; gc++)
        begin : g_catch
            edge_toggle_catcher u_catch
            (
                .pin         (catch_pin[gc]),
                .rst_n       (rst_n),
                .rise_toggle (rise_tog[gc]),
                .fall_toggle (fall_tog[gc])
            );
        end
    endgenerate

    // a changed toggle after synchronising marks one caught edge
    assign rise_ev = st_reg.rise_s2 ^ st_reg.rise_s3;
    assign fall_ev = st_reg.fall_s2 ^ st_reg.fall_s3;

    ////////////////////////////////////////////////////////////////////////
    // edge selection

    // lines 7-4 compare two consecutive synchronised samples
    assign ext_rise = {st_reg.pin_s2[7:4] & ~st_reg.prev_hi,
                       rise_ev[3:0]};
    assign ext_fall = {~st_reg.pin_s2[7:4] & st_reg.prev_hi,
                       fall_ev[3:0]};
    assign sense_all = {st_reg.sense_hi, st_reg.sense_lo};

    // per line trigger decode from its two-bit sense field
    genvar gl;
    generate
        for (gl = 0; gl < ext_irq_pkg::N_LINES; gl++)
        begin : g_line
            logic [1:0] mode;
            assign mode = sense_all[2*gl +: ext_irq_pkg::SENSE_W];
            assign line_lvl[gl] = (mode == ext_irq_pkg::SENSE_LOW);
            assign line_set[gl] =
                ((mode == ext_irq_pkg::SENSE_ANY)
                    & (ext_rise[gl] | ext_fall[gl]))
                | ((mode == ext_irq_pkg::SENSE_FALL) & ext_fall[gl])
                | ((mode == ext_irq_pkg::SENSE_RISE) & ext_rise[gl]);
            assign line_low[gl] = ~st_reg.pin_s2[gl];
        end
    endgenerate

    // pin changes through their per-pin masks
    assign pc_change = rise_ev[16:4] | fall_ev[16:4];
    assign grp_set0 = |(pc_change[7:0] & st_reg.pc_mask0);
    assign grp_set1 = |(pc_change[12:8] & st_reg.pc_mask1);

    ////////////////////////////////////////////////////////////////////////
    // flags

    assign wr_flag  = reg_wr && (reg_addr == ext_irq_pkg::OFS_LINE_FLAG);
    assign wr_gflag = reg_wr && (reg_addr == ext_irq_pkg::OFS_GRP_FLAG);

    // a fresh trigger wins over an ack or a one written in the same cycle;
    // low-level mode holds the flag at zero
    assign flags_nx =
        ((st_reg.flags & ~line_ack & ~({8{wr_flag}} & reg_wdata))
         | line_set) & ~line_lvl;
    assign gflags_nx =
        (st_reg.grp_flags & ~group_ack
         & ~({2{wr_gflag}} & reg_wdata[1:0]))
        | {grp_set1, grp_set0};

    ////////////////////////////////////////////////////////////////////////
    // next state

    // one update of everything; clk_en low freezes it all
    always_comb
    begin
        st_next = st_reg;
        if (clk_en)
        begin
            st_next.pin_s1  = ext_irq_pins;
            st_next.pin_s2  = st_reg.pin_s1;
            st_next.prev_hi = st_reg.pin_s2[7:4];
            st_next.rise_s1 = rise_tog;
            st_next.rise_s2 = st_reg.rise_s1;
            st_next.rise_s3 = st_reg.rise_s2;
            st_next.fall_s1 = fall_tog;
            st_next.fall_s2 = st_reg.fall_s1;
            st_next.fall_s3 = st_reg.fall_s2;
            st_next.flags     = flags_nx;
            st_next.grp_flags = gflags_nx;
            if (reg_wr)
            begin
                unique case (reg_addr)
                    ext_irq_pkg::OFS_SENSE_LO:  st_next.sense_lo = reg_wdata;
                    ext_irq_pkg::OFS_SENSE_HI:  st_next.sense_hi = reg_wdata;
                    ext_irq_pkg::OFS_LINE_MASK: st_next.mask = reg_wdata;
                    ext_irq_pkg::OFS_GRP_EN:
                        st_next.grp_en = reg_wdata[1:0];
                    ext_irq_pkg::OFS_PC_MASK0:  st_next.pc_mask0 = reg_wdata;
                    ext_irq_pkg::OFS_PC_MASK1:
                        st_next.pc_mask1 = reg_wdata[4:0];
                    default: st_next.rdata = st_next.rdata; // flag writes
                endcase
            end
            // read data stands only in the cycle after the strobe
            st_next.rdata = ext_irq_pkg::RST_BYTE;
            if (reg_rd)
            begin
                unique case (reg_addr)
                    ext_irq_pkg::OFS_SENSE_LO:  st_next.rdata = st_reg.sense_lo;
                    ext_irq_pkg::OFS_SENSE_HI:  st_next.rdata = st_reg.sense_hi;
                    ext_irq_pkg::OFS_LINE_MASK: st_next.rdata = st_reg.mask;
                    ext_irq_pkg::OFS_LINE_FLAG: st_next.rdata = st_reg.flags;
                    ext_irq_pkg::OFS_GRP_EN:
                        st_next.rdata = {6'h00, st_reg.grp_en};
                    ext_irq_pkg::OFS_GRP_FLAG:
                        st_next.rdata = {6'h00, st_reg.grp_flags};
                    ext_irq_pkg::OFS_PC_MASK0:  st_next.rdata = st_reg.pc_mask0;
                    ext_irq_pkg::OFS_PC_MASK1:
                        st_next.rdata = {3'h0, st_reg.pc_mask1};
                    default: st_next.rdata = ext_irq_pkg::RST_BYTE;
                endcase
            end
            // requests: level lines follow the synchronised pin directly
            st_next.line_req = {8{global_irq_enable}} & st_reg.mask
                & ((line_lvl & line_low) | (~line_lvl & flags_nx));
            st_next.grp_req0 = global_irq_enable
                & st_reg.grp_en[ext_irq_pkg::GRP0_BIT]
                & gflags_nx[ext_irq_pkg::GRP0_BIT];
            st_next.grp_req1 = global_irq_enable
                & st_reg.grp_en[ext_irq_pkg::GRP1_BIT]
                & gflags_nx[ext_irq_pkg::GRP1_BIT];
        end
    end

    // state register
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign reg_rdata             = st_reg.rdata;
    assign line_req              = st_reg.line_req;
    assign pin_change_req_group0 = st_reg.grp_req0;
    assign pin_change_req_group1 = st_reg.grp_req1;

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    level_flag_zero_a: assert property (
        clk_en |=> (st_reg.flags & $past(line_lvl)) == 8'h00)
        else $error("flag set while line in low-level mode");

    flag_set_wins_a: assert property (
        (clk_en && |(line_set & ~line_lvl))
        |=> (st_reg.flags & $past(line_set) & ~$past(line_lvl))
            == ($past(line_set) & ~$past(line_lvl)))
        else $error("line trigger lost");

    flag_w1c_a: assert property (
        (clk_en && wr_flag && line_set == 8'h00)
        |=> (st_reg.flags & $past(reg_wdata)) == 8'h00)
        else $error("written one did not clear line flag");

    mask_gates_req_a: assert property (
        clk_en |=> (line_req & ~$past(st_reg.mask)) == 8'h00)
        else $error("line request without mask bit");

    gie_gates_req_a: assert property (
        (clk_en && !global_irq_enable)
        |=> line_req == 8'h00 && !pin_change_req_group0
            && !pin_change_req_group1)
        else $error("request while global enable low");

    sync_depth_a: assert property (
        ($past(clk_en, 1) && $past(clk_en, 2)
         && $past(rst_n, 1) && $past(rst_n, 2))
        |-> st_reg.pin_s2 == $past(ext_irq_pins, 2))
        else $error("synchroniser depth wrong");

    group_set_a: assert property (
        (clk_en && grp_set0) |=> st_reg.grp_flags[0] ##0 st_reg.grp_flags[0])
        else $error("group 0 change not flagged");

    group_en_gate_a: assert property (
        (clk_en && !st_reg.grp_en[1]) |=> !pin_change_req_group1)
        else $error("group 1 request while disabled");

    group_ack_a: assert property (
        (clk_en && group_ack[1] && !grp_set1) |=> !st_reg.grp_flags[1])
        else $error("group 1 flag survived its ack");

    read_mask_a: assert property (
        (clk_en && reg_rd && reg_addr == ext_irq_pkg::OFS_LINE_MASK)
        |=> reg_rdata == $past(st_reg.mask) ##1 reg_rdata == 8'h00
            || $past(reg_rd) || !$past(clk_en))
        else $error("mask read data wrong");

    // low-level lines must keep requesting while masked in and low
    level_req_a: assert property (
        (clk_en && global_irq_enable)
        |=> (line_req & $past(st_reg.mask) & $past(line_lvl)
             & $past(line_low))
            == ($past(st_reg.mask) & $past(line_lvl) & $past(line_low)))
        else $error("low level raised no request");

    edge_req_a: assert property (
        (clk_en && global_irq_enable)
        |=> (line_req & $past(st_reg.mask) & $past(line_set)
             & ~$past(line_lvl))
            == ($past(st_reg.mask) & $past(line_set) & ~$past(line_lvl)))
        else $error("triggered line raised no request");

    group_req_a: assert property (
        (clk_en && global_irq_enable && st_reg.grp_en[0] && grp_set0)
        |=> pin_change_req_group0)
        else $error("group 0 change raised no request");

    // an unselected group 1 pin must never reach the group 1 flag
    pc_mask_excl_a: assert property (
        (clk_en && !st_reg.grp_flags[1]
         && (pc_change[12:8] & st_reg.pc_mask1) == 5'h00)
        |=> !st_reg.grp_flags[1])
        else $error("unselected pin set group 1 flag");

    // the catcher toggles cross with the same two-stage depth; the
    // reset terms skip the edges where the stages still hold reset zeros
    catch_sync_a: assert property (
        ($past(clk_en, 1) && $past(clk_en, 2)
         && $past(rst_n, 1) && $past(rst_n, 2))
        |-> st_reg.rise_s2 == $past(rise_tog, 2))
        else $error("edge catcher crossing depth wrong");

endmodule
